// ==== mlfrs_device.sv ====
/*
 * Flash device end: decodes two-lane and four-lane I/O read commands,
 * counts mode and dummy cycles, streams array bytes and keeps the
 * continuous read mode.
 * Assumes the serial clock clocks everything here, the configuration
 * inputs are static while a frame runs, and array_data follows
 * array_addr combinationally.
 */
// Operation
// - BBh 3/4-byte address by select; BCh 4-byte
// - two-lane address: two bits per rising edge
// - host keeps two-lane clock at 104 MHz max
// - basic table two-lane: no mode cycles
// - latency code picks dummies; lanes ignored then
// - enhanced two-lane: four mode cycles after address
// - mode Axh: next frame starts at address
// - only mode upper nibble matters
// - other mode value leaves continuous mode
// - short invalid frame forces continuous mode exit
// - mode cycles count toward access latency
// - host releases two-lane bus before data; with no mode or dummy cycles it releases on the first data edge
// - two data bits per falling edge
// - address increments per byte, wraps to zero
// - host keeps select low through mode, dummy
// - EBh 3/4-byte address by select; ECh 4-byte
// - four-lane read needs four_lane_enable set
// - four-lane address: four bits per edge
// - host keeps four-lane clock at 104 MHz max
// - four-lane dummies same for both tables
// - four-lane always two mode cycles
// - 3-byte four-lane: 8,6,2,4 then nibbles
// - host releases four lanes before data
`timescale 1ns/1ps
`include "mlfrs_regs.svh"
module mlfrs_device #(
   parameter int ADDR_W = 24
) (
   mlfrs_link_if.dev link,
   input wire logic reset,
   input wire logic wide_address_select,
   input wire logic four_lane_enable,
   input wire logic enhanced_latency_table,
   input wire logic [1:0] latency_code,
   output logic [ADDR_W-1:0] array_addr,
   input wire logic [7:0] array_data,
   output logic cont_mode
);
   mlfrs_pkg::mlfrs_dev_t q_r;
   mlfrs_pkg::mlfrs_dev_t q_nxt;
   logic cont_r;
   logic cont_quad_r;
   logic cont_wide_r;
   logic mode_done;
   logic mode_hit;
   logic frame_rst;
   logic [3:0] dout_r;
   logic [3:0] doe_r;
   mlfrs_pkg::mlfrs_dev_st_t st;
   logic quad;
   logic wide;
   logic [5:0] addr_cyc;
   logic [5:0] mode_cyc;
   logic [5:0] dummy;
   logic [15:0] tbl;
   logic [7:0] opc;
   logic [7:0] sh;

   // select high ends the frame; the continuous flags survive it
   assign frame_rst = reset | link.chip_select_n;

   always_comb begin
      st = q_r.st;
      quad = q_r.quad;
      wide = q_r.wide;
      if (q_r.st == mlfrs_pkg::DS_START) begin
         // continuous mode skips the opcode entirely
         st = cont_r ? mlfrs_pkg::DS_ADDR : mlfrs_pkg::DS_OPC;
         quad = cont_quad_r;
         wide = cont_wide_r;
      end
   end

   always_comb begin
      if (quad) begin
         addr_cyc = wide ? `MLFRS_ADDR_CYC_Q4 : `MLFRS_ADDR_CYC_Q3;
         mode_cyc = `MLFRS_MODE_CYC_Q;
         tbl = `MLFRS_DUMMY_QIO;
      end else if (enhanced_latency_table) begin
         addr_cyc = wide ? `MLFRS_ADDR_CYC_D4 : `MLFRS_ADDR_CYC_D3;
         mode_cyc = `MLFRS_MODE_CYC_D;
         tbl = `MLFRS_DUMMY_DIO_ENH;
      end else begin
         addr_cyc = wide ? `MLFRS_ADDR_CYC_D4 : `MLFRS_ADDR_CYC_D3;
         mode_cyc = 6'd0;
         tbl = `MLFRS_DUMMY_DIO_BASIC;
      end
      dummy = {2'b00, tbl[{latency_code, 2'b00} +: 4]};
   end

   always_comb begin
      q_nxt = q_r;
      q_nxt.st = st;
      q_nxt.quad = quad;
      q_nxt.wide = wide;
      mode_done = 1'b0;
      mode_hit = 1'b0;
      opc = {q_r.opc[6:0], link.lane[0]};
      case (st)
         mlfrs_pkg::DS_OPC: begin
            q_nxt.opc = opc;
            q_nxt.cnt = q_r.cnt + 6'd1;
            if (q_r.cnt == `MLFRS_OPC_CYC - 6'd1) begin
               q_nxt.cnt = 6'd0;
               q_nxt.st = mlfrs_pkg::DS_ADDR;
               q_nxt.quad = 1'b0;
               if (opc == `MLFRS_OP_DIO) begin
                  q_nxt.wide = wide_address_select;
               end else if (opc == `MLFRS_OP_DIO_W) begin
                  q_nxt.wide = 1'b1;
               end else if (opc == `MLFRS_OP_QIO && four_lane_enable) begin
                  q_nxt.quad = 1'b1;
                  q_nxt.wide = wide_address_select;
               end else if (opc == `MLFRS_OP_QIO_W && four_lane_enable) begin
                  q_nxt.quad = 1'b1;
                  q_nxt.wide = 1'b1;
               end else begin
                  // other commands belong to other sequencers
                  q_nxt.st = mlfrs_pkg::DS_IGNORE;
               end
            end
         end
         mlfrs_pkg::DS_ADDR: begin
            if (quad) begin
               q_nxt.addr = {q_r.addr[27:0], link.lane};
            end else begin
               q_nxt.addr = {q_r.addr[29:0], link.lane[1:0]};
            end
            q_nxt.cnt = q_r.cnt + 6'd1;
            if (q_r.cnt == addr_cyc - 6'd1) begin
               q_nxt.cnt = 6'd0;
               if (mode_cyc != 6'd0) begin
                  q_nxt.st = mlfrs_pkg::DS_MODE;
               end else if (dummy != 6'd0) begin
                  q_nxt.st = mlfrs_pkg::DS_DUMMY;
               end else begin
                  q_nxt.st = mlfrs_pkg::DS_DATA;
               end
            end
         end
         mlfrs_pkg::DS_MODE: begin
            if (quad) begin
               q_nxt.mode = {q_r.mode[3:0], link.lane};
            end else begin
               q_nxt.mode = {q_r.mode[5:0], link.lane[1:0]};
            end
            q_nxt.cnt = q_r.cnt + 6'd1;
            if (q_r.cnt == mode_cyc - 6'd1) begin
               mode_done = 1'b1;
               // low nibble may float, so it is never looked at
               mode_hit = q_nxt.mode[7:4] == `MLFRS_CONT_NIB;
               q_nxt.cnt = 6'd0;
               // mode cycles already bought part of the access time
               q_nxt.st = (dummy != 6'd0) ? mlfrs_pkg::DS_DUMMY :
                  mlfrs_pkg::DS_DATA;
            end
         end
         mlfrs_pkg::DS_DUMMY: begin
            // lanes are not sampled here, floating is harmless
            q_nxt.cnt = q_r.cnt + 6'd1;
            if (q_r.cnt == dummy - 6'd1) begin
               q_nxt.cnt = 6'd0;
               q_nxt.st = mlfrs_pkg::DS_DATA;
            end
         end
         mlfrs_pkg::DS_DATA: begin
            q_nxt.nib = q_r.nib + 2'd1;
            if ((quad && q_r.nib == 2'd1) || q_r.nib == 2'd3) begin
               q_nxt.nib = 2'd0;
               q_nxt.addr = 32'(q_r.addr[ADDR_W-1:0] + ADDR_W'(1));
            end
         end
         default: begin
            q_nxt.st = mlfrs_pkg::DS_IGNORE;
         end
      endcase
   end

   always_ff @(posedge link.serial_clock or posedge frame_rst) begin
      if (frame_rst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   // continuous mode is dropped at every frame start and only re-armed by
   // a complete Axh mode byte, so short or odd frames always leave it
   always_ff @(posedge link.serial_clock or posedge reset) begin
      if (reset) begin
         cont_r <= 1'b0;
         cont_quad_r <= 1'b0;
         cont_wide_r <= 1'b0;
      end else if (mode_done) begin
         cont_r <= mode_hit;
         cont_quad_r <= quad;
         cont_wide_r <= wide;
      end else if (q_r.st == mlfrs_pkg::DS_START) begin
         cont_r <= 1'b0;
      end
   end

   assign sh = array_data << {q_r.nib, 1'b0};

   always_ff @(negedge link.serial_clock or posedge frame_rst) begin
      if (frame_rst) begin
         dout_r <= 4'h0;
         doe_r <= 4'h0;
      end else if (q_r.st == mlfrs_pkg::DS_DATA && q_r.quad) begin
         dout_r <= q_r.nib[0] ? array_data[3:0] : array_data[7:4];
         doe_r <= 4'hf;
      end else if (q_r.st == mlfrs_pkg::DS_DATA) begin
         dout_r <= {2'b00, sh[7:6]};
         doe_r <= 4'h3;
      end else begin
         dout_r <= 4'h0;
         doe_r <= 4'h0;
      end
   end

   assign link.dev_o = dout_r;
   assign link.dev_oe = doe_r;
   assign array_addr = q_r.addr[ADDR_W-1:0];
   assign cont_mode = cont_r;
endmodule // mlfrs_device

// ==== mlfrs_regs.svh ====
/*
 * Constants of the multi-lane flash read sequencer: opcodes, phase lengths,
 * latency tables and link timing limits.
 * Assumes inclusion by both ends and by the verification side.
 */
`ifndef MLFRS_REGS_SVH
`define MLFRS_REGS_SVH

`define MLFRS_OP_DIO 8'hbb
`define MLFRS_OP_DIO_W 8'hbc
`define MLFRS_OP_QIO 8'heb
`define MLFRS_OP_QIO_W 8'hec
`define MLFRS_CONT_NIB 4'ha
`define MLFRS_OPC_CYC 6'd8
`define MLFRS_ADDR_CYC_D3 6'd12
`define MLFRS_ADDR_CYC_D4 6'd16
`define MLFRS_ADDR_CYC_Q3 6'd6
`define MLFRS_ADDR_CYC_Q4 6'd8
`define MLFRS_MODE_CYC_D 6'd4
`define MLFRS_MODE_CYC_Q 6'd2
`define MLFRS_REL_MODE_D 6'd2
`define MLFRS_REL_MODE_Q 6'd1
// dummy cycles per latency code, one nibble per code, code 0 lowest
`define MLFRS_DUMMY_QIO 16'h1654
`define MLFRS_DUMMY_DIO_BASIC 16'h0654
`define MLFRS_DUMMY_DIO_ENH 16'h0654
`define MLFRS_SCLK_MAX_KHZ 104000
`define MLFRS_CLK_KHZ 20000

`endif

// ==== mlfrs_pkg.sv ====
/*
 * Types shared by both ends of the multi-lane flash read sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mlfrs_pkg;
   typedef enum logic [2:0] {DS_START, DS_OPC, DS_ADDR, DS_MODE, DS_DUMMY,
      DS_DATA, DS_IGNORE} mlfrs_dev_st_t;
   typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_GAP} mlfrs_host_st_t;
   typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_MODE, PH_DUMMY,
      PH_DATA} mlfrs_phase_t;
   typedef struct packed {
      mlfrs_dev_st_t st;
      logic [5:0] cnt;
      logic [7:0] opc;
      logic [31:0] addr;
      logic [7:0] mode;
      logic quad;
      logic wide;
      logic [1:0] nib;
   } mlfrs_dev_t;
   typedef struct packed {
      mlfrs_host_st_t hst;
      mlfrs_phase_t ph;
      logic [7:0] tick;
      logic [5:0] cnt;
      logic [31:0] tx;
      logic [7:0] rx;
      logic [1:0] nib;
      logic [15:0] len;
      logic quad;
      logic wide;
      logic exit;
      logic [5:0] mcyc;
      logic [5:0] dummy;
      logic [7:0] mode;
      logic cs_n;
      logic sclk;
      logic [3:0] lo;
      logic [3:0] loe;
      logic [3:0] sy1;
      logic [3:0] sy2;
      logic rd_valid;
      logic [7:0] rd_data;
   } mlfrs_host_t;
endpackage

// ==== mlfrs_link_if.sv ====
/*
 * Link between host and flash device: chip select, serial clock and four
 * data lanes, each lane resolved from the two ends' output enables.
 * Assumes an idle lane floats high through a pull-up.
 */
`timescale 1ns/1ps
interface mlfrs_link_if;
   logic serial_clock;
   logic chip_select_n;
   logic [3:0] host_o;
   logic [3:0] host_oe;
   logic [3:0] dev_o;
   logic [3:0] dev_oe;
   logic [3:0] lane;

   // pull-up wins when nobody drives
   assign lane = (host_oe & host_o) | (~host_oe & dev_oe & dev_o) |
      (~host_oe & ~dev_oe);

   modport host (
      output serial_clock,
      output chip_select_n,
      output host_o,
      output host_oe,
      input lane
   );
   modport dev (
      input serial_clock,
      input chip_select_n,
      input lane,
      output dev_o,
      output dev_oe
   );
endinterface // mlfrs_link_if

// ==== mlfrs_host.sv ====
/*
 * Host controller end: frames one read command per start request, makes
 * the serial clock by dividing its own clock, and returns read bytes.
 * Assumes command inputs are steady in the cycle of cmd_start.
 */
`timescale 1ns/1ps
`include "mlfrs_regs.svh"
module mlfrs_host #(
   parameter int HALF = 4
) (
   input wire logic clock,
   input wire logic reset,
   mlfrs_link_if.host link,
   input wire logic cmd_start,
   input wire logic cmd_exit,
   input wire logic [7:0] cmd_opcode,
   input wire logic cmd_skip_opcode,
   input wire logic cmd_quad,
   input wire logic cmd_wide,
   input wire logic cmd_enhanced,
   input wire logic [31:0] cmd_addr,
   input wire logic [7:0] cmd_mode,
   input wire logic [3:0] cmd_dummy,
   input wire logic [15:0] cmd_len,
   output logic busy,
   output logic rd_valid,
   output logic [7:0] rd_data
);
   // least half period that keeps the link at or under its top rate
   localparam int MIN_HALF = (`MLFRS_CLK_KHZ + 2 * `MLFRS_SCLK_MAX_KHZ - 1) /
      (2 * `MLFRS_SCLK_MAX_KHZ);
   localparam int H = (HALF > MIN_HALF) ? HALF : MIN_HALF;
   localparam logic [7:0] H_LAST = 8'(H - 1);

   mlfrs_pkg::mlfrs_host_t q_r;
   mlfrs_pkg::mlfrs_host_t q_nxt;
   logic [5:0] acyc;
   logic last;
   // address kept from the start request for the step after the opcode
   logic [31:0] cmd_addr_l;

   always_comb begin
      if (q_r.quad) begin
         acyc = q_r.wide ? `MLFRS_ADDR_CYC_Q4 : `MLFRS_ADDR_CYC_Q3;
      end else begin
         acyc = q_r.wide ? `MLFRS_ADDR_CYC_D4 : `MLFRS_ADDR_CYC_D3;
      end
      case (q_r.ph)
         mlfrs_pkg::PH_OPC: last = q_r.cnt == `MLFRS_OPC_CYC - 6'd1;
         mlfrs_pkg::PH_ADDR: last = q_r.cnt == acyc - 6'd1;
         mlfrs_pkg::PH_MODE: last = q_r.cnt == q_r.mcyc - 6'd1;
         mlfrs_pkg::PH_DUMMY: last = q_r.cnt == q_r.dummy - 6'd1;
         default: last = 1'b0;
      endcase
   end

   always_comb begin
      q_nxt = q_r;
      q_nxt.sy1 = link.lane;
      q_nxt.sy2 = q_r.sy1;
      q_nxt.rd_valid = 1'b0;
      q_nxt.tick = q_r.tick + 8'd1;
      case (q_r.hst)
         mlfrs_pkg::HS_IDLE: begin
            q_nxt.tick = 8'd0;
            if (cmd_start) begin
               q_nxt.hst = mlfrs_pkg::HS_LOW;
               q_nxt.cs_n = 1'b0;
               q_nxt.cnt = 6'd0;
               q_nxt.nib = 2'd0;
               q_nxt.quad = cmd_quad;
               q_nxt.wide = cmd_wide;
               q_nxt.exit = cmd_exit;
               q_nxt.mode = cmd_mode;
               q_nxt.dummy = {2'b00, cmd_dummy};
               q_nxt.len = cmd_len;
               q_nxt.mcyc = cmd_quad ? `MLFRS_MODE_CYC_Q :
                  (cmd_enhanced ? `MLFRS_MODE_CYC_D : 6'd0);
               q_nxt.ph = (cmd_skip_opcode && !cmd_exit) ?
                  mlfrs_pkg::PH_ADDR : mlfrs_pkg::PH_OPC;
               // an exit frame is eight cycles of ones: no valid command
               q_nxt.tx = cmd_exit ? 32'hffff_ffff :
                  (cmd_skip_opcode ? (cmd_wide ? cmd_addr :
                  {cmd_addr[23:0], 8'h00}) : {cmd_opcode, 24'h00_0000});
            end
         end
         mlfrs_pkg::HS_LOW: begin
            if (q_r.tick == H_LAST) begin
               q_nxt.tick = 8'd0;
               q_nxt.sclk = 1'b1;
               q_nxt.hst = mlfrs_pkg::HS_HIGH;
               if (q_r.ph == mlfrs_pkg::PH_DATA) begin
                  q_nxt.rx = q_r.quad ? {q_r.rx[3:0], q_r.sy2} :
                     {q_r.rx[5:0], q_r.sy2[1:0]};
                  q_nxt.nib = q_r.nib + 2'd1;
                  if ((q_r.quad && q_r.nib == 2'd1) || q_r.nib == 2'd3) begin
                     q_nxt.nib = 2'd0;
                     q_nxt.rd_data = q_nxt.rx;
                     q_nxt.rd_valid = 1'b1;
                     q_nxt.len = q_r.len - 16'd1;
                  end
               end
            end
         end
         mlfrs_pkg::HS_HIGH: begin
            if (q_r.tick == H_LAST) begin
               q_nxt.tick = 8'd0;
               q_nxt.sclk = 1'b0;
               q_nxt.hst = mlfrs_pkg::HS_LOW;
               q_nxt.cnt = q_r.cnt + 6'd1;
               if (q_r.ph == mlfrs_pkg::PH_OPC) begin
                  q_nxt.tx = {q_r.tx[30:0], 1'b0};
               end else if (q_r.quad) begin
                  q_nxt.tx = {q_r.tx[27:0], 4'h0};
               end else begin
                  q_nxt.tx = {q_r.tx[29:0], 2'b00};
               end
               if (last) begin
                  q_nxt.cnt = 6'd0;
               end
               // select stays low until the data phase ends, or until the opcode phase ends in an exit frame
               if (last && q_r.ph == mlfrs_pkg::PH_OPC && q_r.exit) begin
                  q_nxt.cs_n = 1'b1;
                  q_nxt.hst = mlfrs_pkg::HS_GAP;
               end else if (last && q_r.ph == mlfrs_pkg::PH_OPC) begin
                  q_nxt.ph = mlfrs_pkg::PH_ADDR;
                  q_nxt.tx = q_r.wide ? cmd_addr_l : {cmd_addr_l[23:0], 8'h00};
               end else if (last && q_r.ph == mlfrs_pkg::PH_ADDR &&
                  q_r.mcyc != 6'd0) begin
                  q_nxt.ph = mlfrs_pkg::PH_MODE;
                  q_nxt.tx = {q_r.mode, 24'h00_0000};
               end else if (last && (q_r.ph == mlfrs_pkg::PH_ADDR ||
                  q_r.ph == mlfrs_pkg::PH_MODE)) begin
                  q_nxt.ph = (q_r.dummy != 6'd0) ? mlfrs_pkg::PH_DUMMY :
                     mlfrs_pkg::PH_DATA;
               end else if (last && q_r.ph == mlfrs_pkg::PH_DUMMY) begin
                  q_nxt.ph = mlfrs_pkg::PH_DATA;
               end else if (q_r.ph == mlfrs_pkg::PH_DATA &&
                  q_r.len == 16'd0) begin
                  q_nxt.cs_n = 1'b1;
                  q_nxt.hst = mlfrs_pkg::HS_GAP;
               end
            end
         end
         default: begin
            if (q_r.tick == H_LAST) begin
               q_nxt.hst = mlfrs_pkg::HS_IDLE;
            end
         end
      endcase
      // lane drive follows the phase; released ahead of the device's data, or on its first edge when no mode or dummy cycles precede it
      q_nxt.lo = 4'h0;
      q_nxt.loe = 4'h0;
      if (q_nxt.cs_n) begin
         q_nxt.loe = 4'h0;
      end else if (q_nxt.ph == mlfrs_pkg::PH_OPC) begin
         q_nxt.lo = {3'b000, q_nxt.tx[31]};
         q_nxt.loe = 4'h1;
      end else if (q_nxt.quad && (q_nxt.ph == mlfrs_pkg::PH_ADDR ||
         (q_nxt.ph == mlfrs_pkg::PH_MODE &&
         q_nxt.cnt < q_nxt.mcyc - `MLFRS_REL_MODE_Q))) begin
         q_nxt.lo = q_nxt.tx[31:28];
         q_nxt.loe = 4'hf;
      end else if (!q_nxt.quad && (q_nxt.ph == mlfrs_pkg::PH_ADDR ||
         (q_nxt.ph == mlfrs_pkg::PH_MODE &&
         q_nxt.cnt < q_nxt.mcyc - `MLFRS_REL_MODE_D))) begin
         q_nxt.lo = {2'b00, q_nxt.tx[31:30]};
         q_nxt.loe = 4'h3;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         q_r <= '0;
         q_r.cs_n <= 1'b1;
         cmd_addr_l <= 32'h0;
      end else begin
         q_r <= q_nxt;
         if (q_r.hst == mlfrs_pkg::HS_IDLE && cmd_start) begin
            cmd_addr_l <= cmd_addr;
         end
      end
   end

   assign link.serial_clock = q_r.sclk;
   assign link.chip_select_n = q_r.cs_n;
   assign link.host_o = q_r.lo;
   assign link.host_oe = q_r.loe;
   assign busy = q_r.hst != mlfrs_pkg::HS_IDLE;
   assign rd_valid = q_r.rd_valid;
   assign rd_data = q_r.rd_data;
endmodule // mlfrs_host

// ==== mlfrs_link_sva.sv ====
/*
 * Checker for the link between host and flash device.
 * Assumes the host clock samples every link signal.
 */
`timescale 1ns/1ps
module mlfrs_link_sva (
   input wire logic clock,
   input wire logic reset,
   input wire logic serial_clock,
   input wire logic chip_select_n,
   input wire logic [3:0] host_oe,
   input wire logic [3:0] dev_o,
   input wire logic [3:0] dev_oe
);
   typedef struct packed {logic sclk_d; logic [7:0] rises;} mlfrs_chk_t;
   mlfrs_chk_t q_r, q_nxt;
   // rising serial clock edges seen in this frame, saturating
   always_comb begin
      q_nxt = q_r;
      q_nxt.sclk_d = serial_clock;
      if (chip_select_n)
         q_nxt.rises = 8'h00;
      else if (serial_clock && !q_r.sclk_d && q_r.rises != 8'hff)
         q_nxt.rises = q_r.rises + 8'h01;
   end
   always_ff @(posedge clock or posedge reset) begin
      if (reset)
         q_r <= '0;
      else
         q_r <= q_nxt;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   a_lane_no_clash: assert property ((host_oe & dev_oe) == 4'h0)
      else $error("host and device drive a lane together");
   a_dev_quiet_idle: assert property (chip_select_n |-> dev_oe == 4'h0)
      else $error("device drives while deselected");
   a_sclk_idle_low: assert property (chip_select_n |-> !serial_clock)
      else $error("serial clock high outside a frame");
   a_sclk_high_hold: assert property ($rose(serial_clock) |-> serial_clock[*3])
      else $error("serial clock high phase too short");
   a_sclk_low_hold: assert property (
      $fell(serial_clock) && !chip_select_n |-> !serial_clock[*3])
      else $error("serial clock low phase too short");
   a_data_on_fall: assert property (
      (dev_oe != 4'h0) && $changed(dev_o) |-> $fell(serial_clock))
      else $error("device data moved off a falling edge");
   // release may fall on the first data edge itself when no mode or dummy cycles precede it
   a_host_released_first: assert property (
      $rose(dev_oe != 4'h0) |-> host_oe == 4'h0)
      else $error("host still driving just before device data");
   a_no_early_data: assert property ((dev_oe != 4'h0) |-> q_r.rises >= 8'd9)
      else $error("device drives before address, mode and dummy");
   a_frame_opens_driven: assert property ($fell(chip_select_n) |=> host_oe[0])
      else $error("host not driving lane 0 at frame start");
   c_quad_data: cover property ($rose(dev_oe == 4'hf));
   c_dual_data: cover property ($rose(dev_oe == 4'h3));
   c_short_frame: cover property ($fell(chip_select_n) ##[1:100]
      $rose(chip_select_n));
endmodule // mlfrs_link_sva

// ==== testbench.sv ====
/*
 * Testbench: host and device joined by the link; the bench plays the
 * memory array and checks every byte read back.
 * Assumes the host answers cmd_start only while idle.
 */
`timescale 1ns/1ps
`include "mlfrs_regs.svh"
module testbench;
   // flags: exit, skip opcode, quad, wide, enhanced
   localparam logic [4:0] DB = 5'b00000, DE = 5'b00001, DW = 5'b00010;
   localparam logic [4:0] QD = 5'b00100, QW = 5'b00110, SQ = 5'b01100;
   localparam logic [4:0] SD = 5'b01001, EX = 5'b10000;
   logic clock, reset, cmd_start, cmd_exit, cmd_skip_opcode, cmd_quad;
   logic cmd_wide, cmd_enhanced, busy, rd_valid, cont_mode;
   logic was, qen, enh;
   logic [1:0] lc;
   logic [7:0] cmd_opcode, cmd_mode, rd_data, array_data;
   logic [31:0] cmd_addr;
   logic [3:0] cmd_dummy;
   logic [15:0] cmd_len;
   logic [23:0] array_addr;
   int fails, n_checks, cyc;

   function automatic logic [7:0] pat(input logic [23:0] p);
      return p[7:0] ^ p[15:8] ^ p[23:16] ^ 8'h3c;
   endfunction
   assign array_data = pat(array_addr);

   function automatic logic [3:0] dmy(input logic q, input logic e,
      input logic [1:0] c);
      logic [15:0] tb;
      tb = q ? `MLFRS_DUMMY_QIO :
         (e ? `MLFRS_DUMMY_DIO_ENH : `MLFRS_DUMMY_DIO_BASIC);
      return tb[4*c +: 4];
   endfunction

   mlfrs_link_if mlfrs_link_if_inst ();
   mlfrs_host #(.HALF(4)) mlfrs_host_inst (.clock(clock), .reset(reset),
      .link(mlfrs_link_if_inst), .cmd_start(cmd_start),
      .cmd_exit(cmd_exit), .cmd_opcode(cmd_opcode),
      .cmd_skip_opcode(cmd_skip_opcode), .cmd_quad(cmd_quad),
      .cmd_wide(cmd_wide), .cmd_enhanced(cmd_enhanced),
      .cmd_addr(cmd_addr), .cmd_mode(cmd_mode), .cmd_dummy(cmd_dummy),
      .cmd_len(cmd_len), .busy(busy), .rd_valid(rd_valid),
      .rd_data(rd_data));
   mlfrs_device #(.ADDR_W(24)) mlfrs_device_inst (
      .link(mlfrs_link_if_inst), .reset(reset),
      .wide_address_select(was), .four_lane_enable(qen),
      .enhanced_latency_table(enh), .latency_code(lc),
      .array_addr(array_addr), .array_data(array_data),
      .cont_mode(cont_mode));
   mlfrs_link_sva mlfrs_link_sva_inst (.clock(clock), .reset(reset),
      .serial_clock(mlfrs_link_if_inst.serial_clock),
      .chip_select_n(mlfrs_link_if_inst.chip_select_n),
      .host_oe(mlfrs_link_if_inst.host_oe),
      .dev_o(mlfrs_link_if_inst.dev_o),
      .dev_oe(mlfrs_link_if_inst.dev_oe));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic tally_and_finish;
      if (fails == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // one frame; undriven lanes read back as the pull-up level
   task automatic go(input logic [7:0] op, input logic [4:0] f,
      input logic [31:0] a, input logic [7:0] m, input logic [15:0] n,
      input logic drv);
      logic [23:0] p;
      int k;
      int t;
      cmd_opcode = op;
      {cmd_exit, cmd_skip_opcode, cmd_quad, cmd_wide, cmd_enhanced} = f;
      cmd_addr = a;
      cmd_mode = m;
      cmd_dummy = dmy(f[2], f[0], lc);
      cmd_len = (n == 16'h0) ? 16'h1 : n;
      p = a[23:0];
      k = 0;
      t = 0;
      cmd_start = 1'b1;
      @(negedge clock);
      cmd_start = 1'b0;
      while (k < n && t < 4000) begin
         @(negedge clock);
         t++;
         if (rd_valid === 1'b1) begin
            chk(rd_data, drv ? pat(p) : 8'hff);
            p++;
            k++;
         end
      end
      while (busy !== 1'b0 && t < 4000) begin
         @(negedge clock);
         t++;
      end
      chk(8'(k), 8'(n));
   endtask

   task automatic t_quad_cont;
      go(`MLFRS_OP_QIO, QD, 32'h00123456, 8'ha5, 3, 1);
      chk({7'h0, cont_mode}, 8'h01);
      go(8'h00, SQ, 32'h00abcdef, 8'h5a, 2, 1);
      chk({7'h0, cont_mode}, 8'h00);
      go(`MLFRS_OP_QIO, QD, 32'h00000100, 8'h00, 1, 1);
   endtask

   task automatic t_dual_basic;
      for (int c = 0; c < 4; c++) begin
         lc = 2'(c);
         go(`MLFRS_OP_DIO, DB, 32'h00001000 + c, 8'ha0, 2, 1);
         chk({7'h0, cont_mode}, 8'h00);
      end
   endtask

   task automatic t_dual_enh;
      enh = 1'b1;
      lc = 2'd2;
      go(`MLFRS_OP_DIO, DE, 32'h00fedcba, 8'ha3, 2, 1);
      chk({7'h0, cont_mode}, 8'h01);
      go(8'h00, SD, 32'h00000fff, 8'haf, 2, 1);
      chk({7'h0, cont_mode}, 8'h01);
      go(8'h00, EX, 32'h0, 8'h00, 0, 1);
      chk({7'h0, cont_mode}, 8'h00);
      enh = 1'b0;
      lc = 2'd0;
   endtask

   // upper address byte set so a short address would misframe
   task automatic t_wide;
      go(`MLFRS_OP_DIO_W, DW, 32'h5affffff, 8'h00, 3, 1);
      go(`MLFRS_OP_QIO_W, QW, 32'ha5fffffe, 8'h00, 4, 1);
      was = 1'b1;
      go(`MLFRS_OP_DIO, DW, 32'h3c000010, 8'h00, 2, 1);
      go(`MLFRS_OP_QIO, QW, 32'hc3000020, 8'h00, 2, 1);
      was = 1'b0;
   endtask

   task automatic t_quad_off;
      qen = 1'b0;
      go(`MLFRS_OP_QIO, QD, 32'h00000040, 8'h00, 2, 0);
      qen = 1'b1;
      enh = 1'b1;
      lc = 2'd3;
      go(`MLFRS_OP_QIO, QD, 32'h00000080, 8'h00, 2, 1);
      enh = 1'b0;
      lc = 2'd0;
   endtask

   initial begin
      {cmd_start, cmd_exit, cmd_skip_opcode, cmd_quad} = 4'h0;
      {cmd_wide, cmd_enhanced, was, enh} = 4'h0;
      qen = 1'b1;
      lc = 2'd0;
      cmd_opcode = 8'h00;
      cmd_mode = 8'h00;
      cmd_addr = 32'h0;
      cmd_dummy = 4'h0;
      cmd_len = 16'h1;
      fails = 0;
      n_checks = 0;
      cyc = 0;
      reset = 1'b1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      reset = 1'b0;
      t_quad_cont();
      t_dual_basic();
      t_dual_enh();
      t_wide();
      t_quad_off();
      tally_and_finish();
   end
endmodule // testbench
